/* include/sddc_map.svh */
`ifndef SDDC_MAP_SVH
`define SDDC_MAP_SVH

// register indices, byte address is four times the index
`define SDDC_IDX_CTRL 6'h13
`define SDDC_IDX_DIV 6'h14
`define SDDC_IDX_OUT0 6'h15
`define SDDC_IDX_OUT1 6'h16
`define SDDC_IDX_OUT2 6'h17
`define SDDC_IDX_STAT 6'h1f

// reset values
`define SDDC_RST_DIV 16'h8082
`define SDDC_RST_OUT 16'h01fc
`define SDDC_RST_CTRL 16'h0004

// divider configuration fields
`define SDDC_INTERP_HI 15
`define SDDC_INTERP_LO 14
`define SDDC_RATIO_HI 13
`define SDDC_RATIO_LO 2
`define SDDC_PRE_HI 1
`define SDDC_PRE_LO 0
`define SDDC_RATIO_MIN 12'h002
`define SDDC_PRE_RSVD 2'h3

// per-output delay fields
`define SDDC_DLY_HI 8
`define SDDC_DLY_LO 2
`define SDDC_PH_HI 1
`define SDDC_PH_LO 0

// generation control fields
`define SDDC_BYP_BIT 6
`define SDDC_CNT_HI 5
`define SDDC_CNT_LO 2
`define SDDC_MODE_HI 1
`define SDDC_MODE_LO 0
`define SDDC_CTRL_MASK 16'h007f

`endif

/* include/sddc_pkg.sv */
package sddc_pkg;

  typedef enum logic [1:0] {
    SDDC_MODE_CONT = 2'b00,
    SDDC_MODE_PULSER = 2'b01,
    SDDC_MODE_REPEAT = 2'b10,
    SDDC_MODE_RETIME = 2'b11
  } sddc_mode_t;

  typedef enum logic [1:0] {
    SDDC_GEN_IDLE = 2'b00,
    SDDC_GEN_CONT = 2'b01,
    SDDC_GEN_BURST = 2'b10,
    SDDC_GEN_REPEAT = 2'b11
  } sddc_gen_state_t;

  typedef struct packed {
    sddc_gen_state_t st;
    logic [1:0] pre_cnt;
    logic [11:0] div_cnt;
    logic [3:0] left;
    logic lvl;
  } sddc_gen_reg_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] div;
    logic [15:0] out0;
    logic [15:0] out1;
    logic [15:0] out2;
    logic ack;
    logic [31:0] dat;
    logic [2:0] ref_lvl;
    logic [5:0] phase_sel;
    logic [20:0] dly;
    logic [4:0] interp;
    logic err;
  } sddc_top_reg_t;

endpackage : sddc_pkg

/* hdl/sddc_frame_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sddc_map.svh"

module sddc_frame_gen
  import sddc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cfg_ok_in,
  input wire logic [1:0] predivide_in,
  input wire logic [11:0] main_ratio_in,
  input wire logic [1:0] mode_in,
  input wire logic [3:0] pulse_count_in,
  input wire logic request_in,
  output logic level_out,
  output logic busy_out
);

  sddc_gen_reg_t q;
  sddc_gen_reg_t d;

  // last pre-divider count for /1, /2, /4
  function automatic logic [1:0] pre_last(input logic [1:0] code);
    case (code)
      2'h0: pre_last = 2'h0;
      2'h1: pre_last = 2'h1;
      default: pre_last = 2'h3;
    endcase
  endfunction : pre_last

  logic tick;
  logic wrap;
  logic high;

  always_comb begin
    d = q;
    tick = (q.pre_cnt == pre_last(predivide_in));
    wrap = tick && (q.div_cnt >= main_ratio_in - 12'h001);
    high = (q.div_cnt < (main_ratio_in >> 1));
    if (!cfg_ok_in) begin
      d.st = SDDC_GEN_IDLE;
      d.pre_cnt = 2'h0;
      d.div_cnt = 12'h000;
      d.left = 4'h0;
      d.lvl = 1'b0;
    end else begin
      // output rate is clock over pre times ratio
      d.pre_cnt = tick ? 2'h0 : q.pre_cnt + 2'h1;
      if (tick) begin
        d.div_cnt = wrap ? 12'h000 : q.div_cnt + 12'h001;
      end
      case (q.st)
        SDDC_GEN_IDLE: begin
          d.lvl = 1'b0;
          if (mode_in == SDDC_MODE_CONT) begin
            d.st = SDDC_GEN_CONT;
          end else if (mode_in == SDDC_MODE_PULSER) begin
            if (request_in) begin
              d.st = SDDC_GEN_BURST;
              d.left = pulse_count_in;
              d.pre_cnt = 2'h0;
              d.div_cnt = 12'h000;
            end
          end else begin
            d.st = SDDC_GEN_REPEAT;
          end
        end
        SDDC_GEN_CONT: begin
          d.lvl = high;
          if (mode_in != SDDC_MODE_CONT) begin
            d.st = SDDC_GEN_IDLE;
          end
        end
        SDDC_GEN_BURST: begin
          d.lvl = high;
          if (wrap) begin
            d.left = q.left - 4'h1;
            if (q.left == 4'h1) begin
              d.st = SDDC_GEN_IDLE;
            end
          end
          if (mode_in != SDDC_MODE_PULSER) begin
            d.st = SDDC_GEN_IDLE;
          end
        end
        SDDC_GEN_REPEAT: begin
          if (mode_in == SDDC_MODE_RETIME) begin
            d.lvl = tick ? request_in : q.lvl;
          end else begin
            d.lvl = request_in;
          end
          if (mode_in == SDDC_MODE_CONT || mode_in == SDDC_MODE_PULSER) begin
            d.st = SDDC_GEN_IDLE;
          end
        end
        default: begin
          d.st = SDDC_GEN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.lvl;
  assign busy_out = (q.st == SDDC_GEN_BURST);

endmodule : sddc_frame_gen

`default_nettype wire

/* hdl/sddc_config.sv */
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sddc_map.svh"

module sddc_config
  import sddc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic frame_ref_request_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic frame_ref_output_0_out,
  output logic frame_ref_output_1_out,
  output logic frame_ref_output_2_out,
  output logic [6:0] out0_delay_step_out,
  output logic [6:0] out1_delay_step_out,
  output logic [6:0] out2_delay_step_out,
  output logic [1:0] out0_phase_select_out,
  output logic [1:0] out1_phase_select_out,
  output logic [1:0] out2_phase_select_out,
  output logic [4:0] interpolator_division_out,
  output logic config_error_out
);

  sddc_top_reg_t q;
  sddc_top_reg_t d;

  // phase code to {quadrature, inverted}
  function automatic logic [1:0] phase_sel(input logic [1:0] code,
                                           input logic swapped);
    case (code)
      2'h0: phase_sel = 2'b01;
      2'h1: phase_sel = 2'b11;
      2'h2: phase_sel = swapped ? 2'b10 : 2'b00;
      default: phase_sel = swapped ? 2'b00 : 2'b10;
    endcase
  endfunction : phase_sel

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_write(input logic [15:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0] sel);
    lane_write = old;
    if (sel[0]) begin
      lane_write[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      lane_write[15:8] = wdat[15:8];
    end
  endfunction : lane_write

  logic [1:0] predivide;
  logic [11:0] main_ratio;
  logic [1:0] interp_code;
  logic delay_bypass;
  logic [3:0] pulse_count;
  logic [1:0] gen_mode;
  logic rsvd_err;
  logic odd_err;
  logic cfg_ok;
  logic gen_level;
  logic gen_busy;
  logic req;
  logic [5:0] idx;
  logic [15:0] status;

  always_comb begin
    predivide = q.div[`SDDC_PRE_HI:`SDDC_PRE_LO];
    main_ratio = q.div[`SDDC_RATIO_HI:`SDDC_RATIO_LO];
    interp_code = q.div[`SDDC_INTERP_HI:`SDDC_INTERP_LO];
    delay_bypass = q.ctrl[`SDDC_BYP_BIT];
    pulse_count = q.ctrl[`SDDC_CNT_HI:`SDDC_CNT_LO];
    gen_mode = q.ctrl[`SDDC_MODE_HI:`SDDC_MODE_LO];
    // reserved predivide code 3, ratio codes 0 and 1, zero pulse count in pulser mode
    rsvd_err = (predivide == `SDDC_PRE_RSVD) ||
               (main_ratio < `SDDC_RATIO_MIN) ||
               ((gen_mode == SDDC_MODE_PULSER) && (pulse_count == 4'h0));
    // odd ratio only under delay bypass
    odd_err = main_ratio[0] && !delay_bypass;
    cfg_ok = !rsvd_err && !odd_err;
    status = {12'h000, gen_level, gen_busy, odd_err, rsvd_err};
  end

  sddc_frame_gen u_gen (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .cfg_ok_in(cfg_ok),
    .predivide_in(predivide),
    .main_ratio_in(main_ratio),
    .mode_in(gen_mode),
    .pulse_count_in(pulse_count),
    .request_in(frame_ref_request_in),
    .level_out(gen_level),
    .busy_out(gen_busy)
  );

  always_comb begin
    d = q;
    req = wb_cyc_in && wb_stb_in && !q.ack;
    idx = wb_adr_in[7:2];
    d.ack = req;
    if (req) begin
      d.dat = 32'h0000_0000;
      case (idx)
        `SDDC_IDX_CTRL: d.dat[15:0] = q.ctrl;
        `SDDC_IDX_DIV: d.dat[15:0] = q.div;
        `SDDC_IDX_OUT0: d.dat[15:0] = q.out0;
        `SDDC_IDX_OUT1: d.dat[15:0] = q.out1;
        `SDDC_IDX_OUT2: d.dat[15:0] = q.out2;
        `SDDC_IDX_STAT: d.dat[15:0] = status;
        default: d.dat = 32'h0000_0000;
      endcase
      if (wb_we_in) begin
        case (idx)
          `SDDC_IDX_CTRL: begin
            d.ctrl = lane_write(q.ctrl, wb_dat_in, wb_sel_in) &
                     `SDDC_CTRL_MASK;
          end
          `SDDC_IDX_DIV: d.div = lane_write(q.div, wb_dat_in, wb_sel_in);
          `SDDC_IDX_OUT0: d.out0 = lane_write(q.out0, wb_dat_in, wb_sel_in);
          `SDDC_IDX_OUT1: d.out1 = lane_write(q.out1, wb_dat_in, wb_sel_in);
          `SDDC_IDX_OUT2: d.out2 = lane_write(q.out2, wb_dat_in, wb_sel_in);
          default: d.ctrl = q.ctrl;
        endcase
      end
    end
    case (interp_code)
      2'h0: d.interp = 5'd2;
      2'h1: d.interp = 5'd4;
      2'h2: d.interp = 5'd8;
      default: d.interp = 5'd16;
    endcase
    d.dly = {q.out2[`SDDC_DLY_HI:`SDDC_DLY_LO],
             q.out1[`SDDC_DLY_HI:`SDDC_DLY_LO],
             q.out0[`SDDC_DLY_HI:`SDDC_DLY_LO]};
    // outputs 1 and 2 phase map
    d.phase_sel = {phase_sel(q.out2[`SDDC_PH_HI:`SDDC_PH_LO], 1'b1),
                   phase_sel(q.out1[`SDDC_PH_HI:`SDDC_PH_LO], 1'b1),
                   phase_sel(q.out0[`SDDC_PH_HI:`SDDC_PH_LO], 1'b0)};
    // divided level drives all three outputs
    d.ref_lvl = {3{gen_level}};
    d.err = !cfg_ok;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q.div <= `SDDC_RST_DIV;
      q.ctrl <= `SDDC_RST_CTRL;
      q.out0 <= `SDDC_RST_OUT;
      q.out1 <= `SDDC_RST_OUT;
      q.out2 <= `SDDC_RST_OUT;
      q.ack <= 1'b0;
      q.dat <= 32'h0000_0000;
      q.ref_lvl <= 3'h0;
      q.phase_sel <= 6'h15;
      q.dly <= 21'h1fffff;
      q.interp <= 5'h08;
      q.err <= 1'b0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    wb_ack_out = q.ack;
    wb_dat_out = q.dat;
    frame_ref_output_0_out = q.ref_lvl[0];
    frame_ref_output_1_out = q.ref_lvl[1];
    frame_ref_output_2_out = q.ref_lvl[2];
    out0_delay_step_out = q.dly[6:0];
    out1_delay_step_out = q.dly[13:7];
    out2_delay_step_out = q.dly[20:14];
    out0_phase_select_out = q.phase_sel[1:0];
    out1_phase_select_out = q.phase_sel[3:2];
    out2_phase_select_out = q.phase_sel[5:4];
    interpolator_division_out = q.interp;
    config_error_out = q.err;
  end

endmodule : sddc_config

`default_nettype wire

/* dv/sddc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module sddc_monitor (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic frame_ref_output_0_out,
  input wire logic frame_ref_output_1_out,
  input wire logic frame_ref_output_2_out,
  input wire logic [4:0] interpolator_division_out,
  input wire logic config_error_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd_ack;
    wb_ack_out && !wb_we_in;
  endsequence

  property p_answer;
    s_taken |=> wb_ack_out;
  endproperty
  a_answer: assert property (p_answer)
    else $error("ack missing one cycle after request");
  property p_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ack longer than one cycle");
  property p_cause;
    wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  a_cause: assert property (p_cause)
    else $error("ack without request");
  property p_upper;
    s_rd_ack |-> wb_dat_out[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("read data upper half not zero");
  property p_unmapped;
    (s_rd_ack ##0 wb_adr_in[7:2] == 6'h00) |-> wb_dat_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_same;
    frame_ref_output_0_out == frame_ref_output_1_out &&
      frame_ref_output_1_out == frame_ref_output_2_out;
  endproperty
  a_same: assert property (p_same)
    else $error("reference outputs differ");
  property p_interp;
    interpolator_division_out inside {5'h2, 5'h4, 5'h8, 5'h10};
  endproperty
  a_interp: assert property (p_interp)
    else $error("illegal interpolator division");
  property p_quiet;
    config_error_out [*4] |-> !frame_ref_output_0_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("output active under bad config");
endmodule : sddc_monitor

`default_nettype wire

/* dv/sddc_conv_model.sv */
`timescale 1ns/10ps
`default_nettype none

module sddc_conv_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [2:0] ref_in,
  output logic [15:0] period_out,
  output logic [15:0] edges_out,
  output logic mismatch_out
);
  logic [15:0] cnt_q;
  logic prev_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 16'h0;
      prev_q <= 1'b0;
      period_out <= 16'h0;
      edges_out <= 16'h0;
      mismatch_out <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 16'h1;
      prev_q <= ref_in[0];
      if (ref_in[0] && !prev_q) begin
        period_out <= cnt_q + 16'h1;
        edges_out <= edges_out + 16'h1;
        cnt_q <= 16'h0;
      end
      if (ref_in != {3{ref_in[0]}}) begin
        mismatch_out <= 1'b1;
      end
    end
  end
endmodule : sddc_conv_model

`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import sddc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] sel = 4'h3;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [2:0] ref_w;
  logic [6:0] st[3];
  logic [1:0] ph[3];
  logic [4:0] interp;
  logic cfg_err, mism;
  logic [15:0] period;
  logic req_w = 1'b0;
  logic [15:0] edges, n0;
  int err_count = 0, samples_checked = 0, seed = 18150;
  int r, p;

  always #10 clk_in = ~clk_in;

  sddc_config dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_sel_in(sel),
    .wb_adr_in(adr), .wb_dat_in(wdat), .frame_ref_request_in(req_w),
    .wb_ack_out(ack), .wb_dat_out(rdat),
    .frame_ref_output_0_out(ref_w[0]), .frame_ref_output_1_out(ref_w[1]),
    .frame_ref_output_2_out(ref_w[2]), .out0_delay_step_out(st[0]),
    .out1_delay_step_out(st[1]), .out2_delay_step_out(st[2]),
    .out0_phase_select_out(ph[0]), .out1_phase_select_out(ph[1]),
    .out2_phase_select_out(ph[2]), .interpolator_division_out(interp),
    .config_error_out(cfg_err));
  sddc_conv_model conv_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .ref_in(ref_w), .period_out(period), .edges_out(edges),
    .mismatch_out(mism));

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : wb

  // expected phase select {quad, inv} for output o and code c
  function automatic logic [1:0] phx(input int o, input logic [1:0] c);
    logic [1:0] m0[4] = '{2'b01, 2'b11, 2'b00, 2'b10};
    logic [1:0] m1[4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    return (o == 0) ? m0[c] : m1[c];
  endfunction : phx

  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    wb(1'b0, 8'h50, 16'h0);
    chk("div", 32'h8082, rd);
    chk("interp", 32'h8, {27'h0, interp});
    for (int o = 0; o < 3; o++) begin
      wb(1'b0, 8'h54 + 8'(4 * o), 16'h0);
      chk("dly", 32'h1fc, rd);
      chk("step", 32'h7f, {25'h0, st[o]});
      chk("ph", 32'h1, {30'h0, ph[o]});
      for (int c = 0; c < 4; c++) begin
        r = $random(seed);
        wb(1'b1, 8'h54 + 8'(4 * o), {7'h0, 7'(r), 2'(c)});
        chk("step", {25'h0, 7'(r)}, {25'h0, st[o]});
        chk("ph", {30'h0, phx(o, 2'(c))}, {30'h0, ph[o]});
      end
    end
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h50, {2'(c), 12'h020, 2'h2});
      chk("interp", 32'h2 << c, {27'h0, interp});
    end
    for (int i = 0; i < 6; i++) begin
      r = 2 + 2 * ($unsigned($random(seed)) % 8);
      p = $unsigned($random(seed)) % 3;
      wb(1'b1, 8'h50, {2'h2, 12'(r), 2'(p)});
      repeat (200) @(posedge clk_in);
      chk("period", 32'(r << p), {16'h0, period});
    end
    wb(1'b1, 8'h50, {2'h2, 12'h020, 2'h3});
    wb(1'b0, 8'h7c, 16'h0);
    chk("stat", 32'h1, {31'h0, rd[0]});
    chk("cfgerr", 32'h1, {31'h0, cfg_err});
    wb(1'b1, 8'h50, {2'h2, 12'h001, 2'h0});
    chk("cfgerr", 32'h1, {31'h0, cfg_err});
    wb(1'b1, 8'h50, {2'h2, 12'h005, 2'h0});
    wb(1'b0, 8'h7c, 16'h0);
    chk("stat", 32'h2, {30'h0, rd[1:0]});
    wb(1'b1, 8'h4c, 16'h0040);
    repeat (100) @(posedge clk_in);
    chk("cfgerr", 32'h0, {31'h0, cfg_err});
    chk("period", 32'h5, {16'h0, period});
    wb(1'b1, 8'h50, {2'h2, 12'h004, 2'h0});
    wb(1'b1, 8'h4c, 16'h000d);
    repeat (4) @(posedge clk_in);
    n0 = edges;
    req_w <= 1'b1;
    @(posedge clk_in);
    req_w <= 1'b0;
    wb(1'b0, 8'h7c, 16'h0);
    chk("busy", 32'h1, {31'h0, rd[2]});
    repeat (40) @(posedge clk_in);
    chk("pulses", 32'h3, {16'h0, 16'(edges - n0)});
    wb(1'b0, 8'h7c, 16'h0);
    chk("busy", 32'h0, {31'h0, rd[2]});
    // repeater and retime modes
    for (int m = 2; m < 4; m++) begin
      wb(1'b1, 8'h4c, 16'h0004 | 16'(m));
      repeat (4) @(posedge clk_in);
      n0 = edges;
      req_w <= 1'b1;
      repeat (3) @(posedge clk_in);
      req_w <= 1'b0;
      repeat (10) @(posedge clk_in);
      chk("repeat", 32'h1, {16'h0, 16'(edges - n0)});
    end
    wb(1'b0, 8'h00, 16'h0);
    chk("unmapped", 32'h0, rd);
    chk("same", 32'h0, {31'h0, mism});
    print_verdict();
  end
endmodule : testbench

bind sddc_config sddc_monitor mon_u (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_ack_out(wb_ack_out),
  .wb_dat_out(wb_dat_out), .frame_ref_output_0_out(frame_ref_output_0_out),
  .frame_ref_output_1_out(frame_ref_output_1_out),
  .frame_ref_output_2_out(frame_ref_output_2_out),
  .interpolator_division_out(interpolator_division_out),
  .config_error_out(config_error_out));

`default_nettype wire
